// *** verilog/crs_defs.svh ***
// Constants for the cluster reset sequencer controller.
// Assumes inclusion by bare name from the verilog/ folder.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
// =====================================================================
// Cluster geometry and clock ratio
`define CRS_NUM_CORES 4
`define CRS_PERIPH_DIV 3
`define CRS_PERIPH_DIV_MIN 2
// =====================================================================
// Timing in main clock cycles
`define CRS_ASSERT_MIN_CYC 9
`define CRS_ASSERT_SAFE_CYC 15
`define CRS_GATE_SETTLE_CYC 10
`define CRS_DEBUG_HOLD_CYC 4
`define CRS_CNT_W 5
// =====================================================================
// Reset kind encodings on the request port
`define CRS_KIND_W 3
`define CRS_KIND_CLU_COLD 3'h0
`define CRS_KIND_CLU_WARM 3'h1
`define CRS_KIND_CORE_COLD 3'h2
`define CRS_KIND_CORE_WARM 3'h3
`define CRS_KIND_SIMD_POR 3'h4
`define CRS_KIND_CLU_DBG 3'h5
`define CRS_KIND_CORE_DBG 3'h6
`define CRS_KIND_WDOG 3'h7
`endif

// *** verilog/crs_pkg.sv ***
// Types for the cluster reset sequencer controller.
// Assumes crs_defs.svh is on the include path.
`include "crs_defs.svh"
package crs_pkg;
  // ===================================================================
  // Sequencer states
  typedef enum logic [5:0] {
    CRS_IDLE   = 6'h01,
    CRS_ASSERT = 6'h02,
    CRS_GATE   = 6'h04,
    CRS_REL    = 6'h08,
    CRS_UNGATE = 6'h10,
    CRS_DBG    = 6'h20
  } crs_state_e;
  typedef logic [`CRS_NUM_CORES-1:0] crs_mask_t;
endpackage : crs_pkg

// *** verilog/crs_periph_clk.sv ***
// Peripheral clock pulse generator, a divider on the main clock.
// Assumes the controller clock is the cluster main clock.
`timescale 1ns/100ps
`default_nettype none
`include "crs_defs.svh"
module crs_periph_clk (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  output logic      periph_clock_out,
  output logic      periph_pulse_out
);
  // ===================================================================
  // Divide counter
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       clk_r;
  logic       clk_nxt;
  logic       pls_r;
  logic       pls_nxt;
  always_comb begin
    cnt_nxt = 4'h0;
    clk_nxt = 1'b0;
    pls_nxt = 1'b0;
    if (run_in) begin
      cnt_nxt = (cnt_r == 4'(`CRS_PERIPH_DIV - 1)) ? 4'h0 : cnt_r + 4'h1;
      clk_nxt = (cnt_nxt < 4'(`CRS_PERIPH_DIV / 2));
      pls_nxt = (cnt_nxt == 4'(`CRS_PERIPH_DIV - 1));
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 4'h0;
      clk_r <= 1'b0;
      pls_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      pls_r <= pls_nxt;
    end
  end
  assign periph_clock_out = clk_r;
  assign periph_pulse_out = pls_r;
  // ===================================================================
  // Checks
  ratio_min_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    pls_r |=> !pls_r) else $error("pulse too frequent");
  pulse_edge_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(clk_r) |-> $past(pls_r)) else $error("pulse not ahead of rising edge");
endmodule : crs_periph_clk
`default_nettype wire

// *** verilog/crs_sequencer.sv ***
// Reset sequencer that drives the reset and clock-gate inputs of a cluster.
// Assumes requests come from logic on the main clock; all outputs are
// synchronous to that clock.
// What this block does
// - All cluster signals synchronous to main clock
// - Peripheral clock is main clock divided by N>=2
// - Peripheral pulse marks next peripheral rising edge, one cycle ahead
// - Peripheral clock may stop when unused
// - Cluster cold: every reset driven low
// - Cluster warm: as cold, debug stays high
// - Core cold: core, SIMD, debug of n low
// - Core warm: core n, SIMD n low, flag n too if req_wdog_in
// - Watchdog flag: only flag reset n low
// - Cold cluster reset applied at power-up
// - Release resets synchronously using clock gates
// - Hold asserted resets at least nine cycles; debug and watchdog kinds hold four
// - Safe hold of fifteen cycles supplied
// - Gate, wait eleven, release, wait ten, ungate
// - Warm cluster never asserts debug resets
// - Core cold gates core n like cluster
// - Per-core resets keep other cores' debug
// - SIMD reset: hold, gate, release, ungate
// - Cluster debug: gates stay deasserted throughout
// - Core debug: core n gates stay deasserted
`timescale 1ns/100ps
`default_nettype none
`include "crs_defs.svh"
module crs_sequencer (
  input  wire logic                          clk_sys_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          req_valid_in,
  input  wire logic [`CRS_KIND_W-1:0]        req_kind_in,
  input  wire logic [1:0]                    req_core_in,
  input  wire logic                          req_wdog_in,
  input  wire logic                          periph_run_in,
  output logic                               req_ready_out,
  output logic                               busy_out,
  output logic                               coherency_ctrl_reset_n_out,
  output logic                               private_periph_reset_n_out,
  output logic [`CRS_NUM_CORES-1:0]          core_reset_n_out,
  output logic [`CRS_NUM_CORES-1:0]          simd_reset_n_out,
  output logic [`CRS_NUM_CORES-1:0]          debug_reset_n_out,
  output logic [`CRS_NUM_CORES-1:0]          wdog_flag_reset_n_out,
  output logic [`CRS_NUM_CORES-1:0]          core_clock_gate_out,
  output logic [`CRS_NUM_CORES-1:0]          simd_clock_gate_out,
  output logic                               peripheral_clock_out,
  output logic                               peripheral_clock_pulse_out
);
  // ===================================================================
  // State
  crs_pkg::crs_state_e           st_r, st_nxt;
  logic [`CRS_CNT_W-1:0]         cnt_r, cnt_nxt;
  logic                          por_r, por_nxt;
  logic                          clu_r, clu_nxt;
  logic                          dbg_r, dbg_nxt;
  logic                          wdo_r, wdo_nxt;
  crs_pkg::crs_mask_t            cmask_r, cmask_nxt;
  crs_pkg::crs_mask_t            smask_r, smask_nxt;
  crs_pkg::crs_mask_t            dmask_r, dmask_nxt;
  crs_pkg::crs_mask_t            wmask_r, wmask_nxt;
  crs_pkg::crs_mask_t            cgate_r, cgate_nxt;
  crs_pkg::crs_mask_t            sgate_r, sgate_nxt;
  crs_pkg::crs_mask_t            one_n;
  logic                          take;

  assign one_n = crs_pkg::crs_mask_t'(4'h1) << req_core_in;
  assign req_ready_out = (st_r == crs_pkg::CRS_IDLE) && !por_r;
  assign take = req_valid_in && req_ready_out;
  assign busy_out = (st_r != crs_pkg::CRS_IDLE) || por_r;

  // ===================================================================
  // Next state
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    por_nxt   = por_r;
    clu_nxt   = clu_r;
    dbg_nxt   = dbg_r;
    wdo_nxt   = wdo_r;
    cmask_nxt = cmask_r;
    smask_nxt = smask_r;
    dmask_nxt = dmask_r;
    wmask_nxt = wmask_r;
    cgate_nxt = cgate_r;
    sgate_nxt = sgate_r;
    unique case (st_r)
      crs_pkg::CRS_IDLE: begin
        cnt_nxt = '0;
        if (por_r) begin
          por_nxt   = 1'b0;
          clu_nxt   = 1'b1;
          cmask_nxt = '1;
          smask_nxt = '1;
          dmask_nxt = '1;
          wmask_nxt = '1;
          st_nxt    = crs_pkg::CRS_ASSERT;
        end else if (take) begin
          clu_nxt   = 1'b0;
          dbg_nxt   = 1'b0;
          wdo_nxt   = 1'b0;
          cmask_nxt = '0;
          smask_nxt = '0;
          dmask_nxt = '0;
          wmask_nxt = '0;
          st_nxt    = crs_pkg::CRS_ASSERT;
          case (req_kind_in)
            `CRS_KIND_CLU_COLD: begin
              clu_nxt = 1'b1;
              cmask_nxt = '1;
              smask_nxt = '1;
              dmask_nxt = '1;
              wmask_nxt = '1;
            end
            `CRS_KIND_CLU_WARM: begin
              clu_nxt = 1'b1;
              cmask_nxt = '1;
              smask_nxt = '1;
              wmask_nxt = '1;
            end
            `CRS_KIND_CORE_COLD: begin
              cmask_nxt = one_n;
              smask_nxt = one_n;
              dmask_nxt = one_n;
              wmask_nxt = req_wdog_in ? one_n : '0;
            end
            `CRS_KIND_CORE_WARM: begin
              cmask_nxt = one_n;
              smask_nxt = one_n;
              wmask_nxt = req_wdog_in ? one_n : '0;
            end
            `CRS_KIND_SIMD_POR: begin
              smask_nxt = one_n;
            end
            `CRS_KIND_CLU_DBG: begin
              dbg_nxt = 1'b1;
              dmask_nxt = '1;
              st_nxt = crs_pkg::CRS_DBG;
            end
            `CRS_KIND_CORE_DBG: begin
              dbg_nxt = 1'b1;
              dmask_nxt = one_n;
              st_nxt = crs_pkg::CRS_DBG;
            end
            default: begin
              wdo_nxt = 1'b1;
              wmask_nxt = one_n;
              st_nxt = crs_pkg::CRS_DBG;
            end
          endcase
        end
      end
      crs_pkg::CRS_ASSERT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `CRS_CNT_W'(`CRS_ASSERT_SAFE_CYC - 1)) begin
          cnt_nxt   = '0;
          cgate_nxt = cmask_r;
          sgate_nxt = smask_r;
          st_nxt    = crs_pkg::CRS_GATE;
        end
      end
      crs_pkg::CRS_GATE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `CRS_CNT_W'(`CRS_GATE_SETTLE_CYC - 1)) begin
          cnt_nxt = '0;
          st_nxt  = crs_pkg::CRS_REL;
        end
      end
      crs_pkg::CRS_REL: begin
        clu_nxt   = 1'b0;
        cmask_nxt = '0;
        smask_nxt = '0;
        dmask_nxt = '0;
        wmask_nxt = '0;
        st_nxt    = crs_pkg::CRS_UNGATE;
      end
      crs_pkg::CRS_UNGATE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `CRS_CNT_W'(`CRS_GATE_SETTLE_CYC - 1)) begin
          cnt_nxt   = '0;
          cgate_nxt = '0;
          sgate_nxt = '0;
          st_nxt    = crs_pkg::CRS_IDLE;
        end
      end
      crs_pkg::CRS_DBG: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `CRS_CNT_W'(`CRS_DEBUG_HOLD_CYC - 1)) begin
          cnt_nxt   = '0;
          dmask_nxt = '0;
          wmask_nxt = '0;
          dbg_nxt   = 1'b0;
          wdo_nxt   = 1'b0;
          st_nxt    = crs_pkg::CRS_IDLE;
        end
      end
      default: begin
        st_nxt = crs_pkg::CRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r    <= crs_pkg::CRS_IDLE;
      cnt_r   <= '0;
      por_r   <= 1'b1;
      clu_r   <= 1'b1;
      dbg_r   <= 1'b0;
      wdo_r   <= 1'b0;
      cmask_r <= '1;
      smask_r <= '1;
      dmask_r <= '1;
      wmask_r <= '1;
      cgate_r <= '0;
      sgate_r <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      por_r   <= por_nxt;
      clu_r   <= clu_nxt;
      dbg_r   <= dbg_nxt;
      wdo_r   <= wdo_nxt;
      cmask_r <= cmask_nxt;
      smask_r <= smask_nxt;
      dmask_r <= dmask_nxt;
      wmask_r <= wmask_nxt;
      cgate_r <= cgate_nxt;
      sgate_r <= sgate_nxt;
    end
  end

  // ===================================================================
  // Outputs, all registered on the main clock
  assign coherency_ctrl_reset_n_out = !clu_r;
  assign private_periph_reset_n_out = !clu_r;
  assign core_reset_n_out           = ~cmask_r;
  assign simd_reset_n_out           = ~smask_r;
  assign debug_reset_n_out          = ~dmask_r;
  assign wdog_flag_reset_n_out      = ~wmask_r;
  assign core_clock_gate_out        = cgate_r;
  assign simd_clock_gate_out        = sgate_r;

  crs_periph_clk u_periph (
    .clk_sys_in       (clk_sys_in),
    .sys_rst_in       (sys_rst_in),
    .run_in           (periph_run_in),
    .periph_clock_out (peripheral_clock_out),
    .periph_pulse_out (peripheral_clock_pulse_out)
  );

  // ===================================================================
  // Checks
  logic any_rst;
  assign any_rst = clu_r || (|cmask_r) || (|smask_r);

  hold_nine_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(any_rst) |-> any_rst [*8] ##1 any_rst) else $error("reset held short");
  release_gated_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ($fell(clu_r) || $changed(cmask_r) && !(|cmask_r)) |-> (|cgate_r || |sgate_r))
    else $error("release without gate");
  ungate_wait_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $fell(st_r == crs_pkg::CRS_REL) |-> (|cgate_r || |sgate_r) [*8] ##2 1'b1)
    else $error("ungate too early");
  warm_debug_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (take && req_kind_in == `CRS_KIND_CLU_WARM) |=> dmask_r == '0)
    else $error("warm asserted debug");
  core_warm_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (take && req_kind_in == `CRS_KIND_CORE_WARM) |=> (dmask_r == '0 && $onehot(cmask_r)))
    else $error("core warm asserted debug");
  dbg_nogate_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_r == crs_pkg::CRS_DBG) |-> (cgate_r == '0 && sgate_r == '0 && !clu_r))
    else $error("gate during debug");
  dbg_only_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    dbg_r |-> (!clu_r && cmask_r == '0 && smask_r == '0 && wmask_r == '0 && |dmask_r))
    else $error("debug reset not alone");
  wdog_only_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wdo_r |-> (cmask_r == '0 && smask_r == '0 && dmask_r == '0 && $onehot(wmask_r)))
    else $error("watchdog reset not alone");
  simd_only_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (take && req_kind_in == `CRS_KIND_SIMD_POR) |=> (cmask_r == '0 && $onehot(smask_r)))
    else $error("simd reset touches core");
  por_first_a: assert property (@(posedge clk_sys_in)
    $fell(sys_rst_in) |-> clu_r && (&dmask_r) && (&wmask_r))
    else $error("power-up reset missing");
  ready_idle_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    take |=> !req_ready_out) else $error("ready while busy");

  cold_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    take && req_kind_in == `CRS_KIND_CORE_COLD);
  simd_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    take && req_kind_in == `CRS_KIND_SIMD_POR);
  dbg_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    take && req_kind_in == `CRS_KIND_CLU_DBG);
  done_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $fell(busy_out));
  wdog_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    take && req_kind_in == `CRS_KIND_WDOG);
endmodule : crs_sequencer
`default_nettype wire

// *** tb/crs_cluster_model.sv ***
// Behavioural cluster model: per core debug state and watchdog flag.
// Assumes reset inputs come from the sequencer and load_in from the bench, all on the main clock.
`timescale 1ns/100ps
`default_nettype none
module crs_cluster_model (
  input  wire logic       clk_sys_in,
  input  wire logic       load_in,
  input  wire logic [3:0] debug_reset_n_in,
  input  wire logic [3:0] wdog_flag_reset_n_in,
  output logic      [3:0] debug_kept_out,
  output logic      [3:0] wdog_flag_out
);
  // ==================================================================
  // State sampled on the main clock only
  always_ff @(posedge clk_sys_in) begin
    for (int i = 0; i < 4; i++) begin
      if (!debug_reset_n_in[i]) debug_kept_out[i] <= 1'b0;
      else if (load_in) debug_kept_out[i] <= 1'b1;
      if (!wdog_flag_reset_n_in[i]) wdog_flag_out[i] <= 1'b0;
      else if (load_in) wdog_flag_out[i] <= 1'b1;
    end
  end
endmodule : crs_cluster_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the cluster reset sequencer.
// Assumes the design files and the cluster model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk_sys_in    = 1'b0;
  logic       sys_rst_in    = 1'b1;
  logic       req_valid_in  = 1'b0;
  logic [2:0] req_kind_in   = 3'h0;
  logic [1:0] req_core_in   = 2'h0;
  logic       req_wdog_in   = 1'b0;
  logic       periph_run_in = 1'b1;
  logic       load          = 1'b0;
  logic       ready, busy, coh_n, per_n, pclk, ppulse;
  logic [3:0] core_n, simd_n, dbg_n, wd_n, cgate, sgate, kept, flag;
  int         mismatches    = 0;
  int         checks_done   = 0;
  int         cycles        = 0;
  // ==================================================================
  // Design and cluster model
  crs_sequencer dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid_in), .req_kind_in(req_kind_in),
    .req_core_in(req_core_in), .req_wdog_in(req_wdog_in),
    .periph_run_in(periph_run_in), .req_ready_out(ready), .busy_out(busy),
    .coherency_ctrl_reset_n_out(coh_n), .private_periph_reset_n_out(per_n),
    .core_reset_n_out(core_n), .simd_reset_n_out(simd_n),
    .debug_reset_n_out(dbg_n), .wdog_flag_reset_n_out(wd_n),
    .core_clock_gate_out(cgate), .simd_clock_gate_out(sgate),
    .peripheral_clock_out(pclk), .peripheral_clock_pulse_out(ppulse));
  crs_cluster_model model_u (.clk_sys_in(clk_sys_in), .load_in(load),
    .debug_reset_n_in(dbg_n), .wdog_flag_reset_n_in(wd_n),
    .debug_kept_out(kept), .wdog_flag_out(flag));
  // ==================================================================
  // Clock, timeout and shared tasks
  always #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic [17:0] lows();
    return ~{coh_n, per_n, core_n, simd_n, dbg_n, wd_n};
  endfunction : lows
  function automatic logic [17:0] exp_low(input logic [2:0] k, input logic [1:0] n,
                                          input logic w);
    logic [3:0] oh;
    oh = 4'h1 << n;
    case (k)
      3'h0: return 18'h3FFFF;
      3'h1: return 18'h3FF0F;
      3'h2: return {2'h0, oh, oh, oh, w ? oh : 4'h0};
      3'h3: return {2'h0, oh, oh, 4'h0, w ? oh : 4'h0};
      3'h4: return {6'h00, oh, 8'h00};
      3'h5: return {10'h000, 4'hF, 4'h0};
      3'h6: return {10'h000, oh, 4'h0};
      default: return {14'h0000, oh};
    endcase
  endfunction : exp_low
  task automatic pulse_load();
    @(posedge clk_sys_in);
    load <= 1'b1;
    @(posedge clk_sys_in);
    load <= 1'b0;
  endtask : pulse_load
  task automatic issue(input logic [2:0] k, input logic [1:0] n, input logic w);
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 200) begin
      @(posedge clk_sys_in);
      #1;
      t++;
    end
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in  <= k;
    req_core_in  <= n;
    req_wdog_in  <= w;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
  endtask : issue
  task automatic watch(input logic [17:0] el, input logic [7:0] eg, input int eu,
                       input int eo);
    int lo, ov, af, t;
    logic [7:0]  g;
    logic [17:0] any;
    lo = 0;
    ov = 0;
    af = 0;
    t = 0;
    g = 8'h00;
    any = 18'h00000;
    #1;
    check("first pattern", lows(), el);
    check("busy", busy, 1'b1);
    while (ready !== 1'b1 && t < 100) begin
      any = any | lows();
      g = g | {cgate, sgate};
      if (lows() != 0 && {cgate, sgate} == 0) lo++;
      if (lows() != 0 && {cgate, sgate} != 0) ov++;
      if (lows() == 0 && {cgate, sgate} != 0) af++;
      @(posedge clk_sys_in);
      #1;
      t++;
    end
    check("asserted set", any, el);
    check("gates used", g, eg);
    if (eg != 0) check("min hold", lo >= 9, 1'b1);
    if (eu > 0) check("hold", lo, eu);
    // Release state adds one gated cycle ahead of the release edge
    check("gated before release", ov, (eo != 0) ? eo + 1 : 0);
    check("gated after release", af, eo);
    check("idle", {lows(), cgate, sgate}, 26'h0000000);
  endtask : watch
  // ==================================================================
  // Scenarios
  task automatic t_power_up();
    watch(18'h3FFFF, 8'hFF, 0, 10);
  endtask : t_power_up
  task automatic t_cluster();
    pulse_load();
    issue(3'h1, 2'h0, 1'b0);
    watch(exp_low(3'h1, 2'h0, 1'b0), 8'hFF, 15, 10);
    check("debug kept warm", kept, 4'hF);
    check("flags warm", flag, 4'h0);
    issue(3'h0, 2'h0, 1'b0);
    watch(exp_low(3'h0, 2'h0, 1'b0), 8'hFF, 15, 10);
    check("debug cold", kept, 4'h0);
  endtask : t_cluster
  task automatic t_core();
    pulse_load();
    issue(3'h3, 2'h3, 1'b0);
    watch(exp_low(3'h3, 2'h3, 1'b0), 8'h88, 15, 10);
    check("debug kept core warm", kept, 4'hF);
    check("flags core warm", flag, 4'hF);
    issue(3'h2, 2'h0, 1'b1);
    watch(exp_low(3'h2, 2'h0, 1'b1), 8'h11, 15, 10);
    check("debug core cold", kept, 4'hE);
    check("flags core cold", flag, 4'hE);
  endtask : t_core
  task automatic t_simd_dbg();
    issue(3'h4, 2'h1, 1'b0);
    watch(exp_low(3'h4, 2'h1, 1'b0), 8'h02, 15, 10);
    pulse_load();
    issue(3'h5, 2'h0, 1'b0);
    watch(exp_low(3'h5, 2'h0, 1'b0), 8'h00, 4, 0);
    pulse_load();
    issue(3'h6, 2'h2, 1'b0);
    watch(exp_low(3'h6, 2'h2, 1'b0), 8'h00, 4, 0);
    check("debug per core", kept, 4'hB);
  endtask : t_simd_dbg
  task automatic t_wdog_refuse();
    pulse_load();
    issue(3'h7, 2'h1, 1'b0);
    watch(exp_low(3'h7, 2'h1, 1'b0), 8'h00, 4, 0);
    check("flag one core", flag, 4'hD);
    issue(3'h5, 2'h0, 1'b0);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in  <= 3'h7;
    #1;
    check("ready while busy", ready, 1'b0);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    #1;
    check("refused kind early", wd_n, 4'hF);
    repeat (8) @(posedge clk_sys_in);
    #1;
    check("refused kind", wd_n, 4'hF);
  endtask : t_wdog_refuse
  task automatic t_periph();
    int p;
    logic c, u;
    p = 0;
    @(posedge clk_sys_in);
    #1;
    repeat (30) begin
      c = pclk;
      u = ppulse;
      p += u;
      @(posedge clk_sys_in);
      #1;
      check("pulse at edge", pclk & ~c, u);
    end
    check("pulses", p, 10);
    @(posedge clk_sys_in);
    periph_run_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    repeat (6) begin
      @(posedge clk_sys_in);
      #1;
      check("held clock", pclk, 1'b0);
      check("held pulse", ppulse, 1'b0);
    end
    @(posedge clk_sys_in);
    periph_run_in <= 1'b1;
  endtask : t_periph
  initial begin
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_power_up();
    t_cluster();
    t_core();
    t_simd_dbg();
    t_wdog_refuse();
    t_periph();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
